// file: src/mdr_pkg.sv
// Shared constants and state types for the memory dump reply readout link.
package mdr_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] MDR_OP_DUMP = 8'h94;
  localparam logic [7:0] MDR_OP_READ = 8'h00;

  // ==========================================================================
  // Dump parameter layout
  localparam logic [2:0] MDR_LAST_PARAM  = 3'h6;
  localparam int         MDR_PARAM_BITS  = 56;
  localparam int         MDR_ADDR_BITS   = 20;
  localparam int         MDR_COUNT_BITS  = 20;
  localparam int         MDR_ADDR_LSB    = 32;
  localparam logic [3:0] MDR_DUMP_BYTES  = 4'h8;
  localparam logic [3:0] MDR_QUERY_BYTES = 4'h1;

  // ==========================================================================
  // Reply framing and buffer
  localparam logic [7:0] MDR_QUERY_COUNT = 8'h00;
  localparam logic [1:0] MDR_LAST_BYTE   = 2'h3;
  localparam logic [1:0] MDR_FIFO_DEPTH  = 2'h2;
  localparam int         MDR_FIFO_ENTRY  = 2;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] MDR_BYTE_RST = 8'h00;

  // ==========================================================================
  // State machines
  typedef enum logic [4:0] {
    MDR_D_IDLE  = 5'h01,
    MDR_D_PARAM = 5'h02,
    MDR_D_FETCH = 5'h04,
    MDR_D_SPLIT = 5'h08,
    MDR_D_QUERY = 5'h10
  } mdr_dev_state_e;

  typedef enum logic [3:0] {
    MDR_H_IDLE   = 4'h1,
    MDR_H_SEND   = 4'h2,
    MDR_H_RDCMD  = 4'h4,
    MDR_H_RDWAIT = 4'h8
  } mdr_host_state_e;

endpackage

// file: src/mdr_link_if.sv
// Byte-wide command and reply link between host and device.
`timescale 1ns/1ps
interface mdr_link_if;
  logic       cmd_valid;
  logic       cmd_ready;
  logic [7:0] cmd_byte;
  logic       rep_valid;
  logic       rep_ready;
  logic [7:0] rep_byte;

  modport dev (
    input  cmd_valid,
    input  cmd_byte,
    input  rep_ready,
    output cmd_ready,
    output rep_valid,
    output rep_byte
  );

  modport hst (
    output cmd_valid,
    output cmd_byte,
    output rep_ready,
    input  cmd_ready,
    input  rep_valid,
    input  rep_byte
  );
endinterface

// file: src/mdr_dump_device.sv
// Device end: command parser, memory dump fetcher and reply readout.
`timescale 1ns/1ps
// Summary of operation
// - Dump byte, three address, four count bytes.
// - Fetch N consecutive words as reply data.
// - Only low twenty address bits are used.
// - Count is twenty bits; host stays in range.
// - Host issues four reads per dumped word.
// - After the last byte is buffered, return to idle command state.
// - Zero byte read returns one reply byte.
// - Host reads at least once after queries.
// - Reply: count word, then interpreter status.
module mdr_dump_device (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Link to the host.
  mdr_link_if.dev          link,
  // Memory read port.
  output logic             mem_req,
  output logic [19:0]      mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // Interpreter status and activity.
  input  wire logic [7:0]  interpreter_status_word,
  output logic             dump_busy
);

  // ==========================================================================
  // State and storage
  mdr_pkg::mdr_dev_state_e state_r;
  mdr_pkg::mdr_dev_state_e state_nxt;
  logic [55:0] param_r;
  logic [2:0]  pcnt_r;
  logic [19:0] addr_r;
  logic [19:0] left_r;
  logic [31:0] word_r;
  logic [1:0]  bidx_r;
  logic        qidx_r;
  logic        ready_r;
  logic        rep_valid_r;
  logic [7:0]  rep_byte_r;
  logic        mem_req_r;
  logic        busy_r;
  logic [7:0]  fifo_mem_r [0:1];
  logic        wr_ptr_r;
  logic        rd_ptr_r;
  logic [1:0]  fcnt_r;

  // ==========================================================================
  // Command decode
  wire        in_idle    = (state_r == mdr_pkg::MDR_D_IDLE);
  wire        in_param   = (state_r == mdr_pkg::MDR_D_PARAM);
  wire        in_fetch   = (state_r == mdr_pkg::MDR_D_FETCH);
  wire        in_split   = (state_r == mdr_pkg::MDR_D_SPLIT);
  wire        in_query   = (state_r == mdr_pkg::MDR_D_QUERY);
  wire        take       = link.cmd_valid & ready_r;
  wire        is_read    = (link.cmd_byte == mdr_pkg::MDR_OP_READ);
  wire        is_dump    = (link.cmd_byte == mdr_pkg::MDR_OP_DUMP);
  wire        take_param = take & in_param;
  // After the dump parameters, every byte is taken as a read until idle.
  wire        take_read  = take & ~in_param & (~in_idle | is_read);
  wire        take_dump  = take & in_idle & is_dump;
  wire        take_query = take & in_idle & ~is_read & ~is_dump;
  wire        last_param = take_param & (pcnt_r == mdr_pkg::MDR_LAST_PARAM);
  // The seventh byte completes the field as it arrives.
  wire [55:0] param_full = {param_r[47:0], link.cmd_byte};
  wire [19:0] start_addr =
    param_full[mdr_pkg::MDR_ADDR_LSB +: mdr_pkg::MDR_ADDR_BITS];
  wire [19:0] word_count = param_full[19:0];

  // ==========================================================================
  // Buffer decode
  wire        fifo_has   = (fcnt_r != 2'h0);
  wire        fifo_room  = (fcnt_r != mdr_pkg::MDR_FIFO_DEPTH);
  wire [7:0]  fifo_head  = fifo_mem_r[rd_ptr_r];
  wire        pop        = take_read & fifo_has;
  wire [31:0] word_sh    = word_r << {bidx_r, 3'h0};
  wire [7:0]  split_byte = word_sh[31:24];
  wire [7:0]  query_byte = qidx_r ? interpreter_status_word : mdr_pkg::MDR_QUERY_COUNT;
  wire        push_req   = in_split | in_query;
  wire        push       = push_req & fifo_room;
  wire [7:0]  push_byte  = in_split ? split_byte : query_byte;
  wire        last_split = push & in_split & (bidx_r == mdr_pkg::MDR_LAST_BYTE);
  wire        last_query = push & in_query & qidx_r;
  // An empty buffer in idle answers with the interpreter status byte.
  wire [7:0]  reply_src  = fifo_has ? fifo_head : interpreter_status_word;
  wire [1:0]  fcnt_nxt   = fcnt_r + {1'b0, push} - {1'b0, pop};

  // ==========================================================================
  // Ready decode
  // Every condition here can only be spoiled by a take, so a raised ready
  // never points at a byte that would be refused.
  wire        ok_idle    = in_idle & ~rep_valid_r;
  wire        ok_dump    = (in_fetch | in_split) & ~rep_valid_r & fifo_has;
  wire        ready_nxt  = (in_param | ok_idle | ok_dump) & ~take;
  wire        rep_free   = rep_valid_r & link.rep_ready;

  // ==========================================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      mdr_pkg::MDR_D_IDLE: begin
        if (take_dump) begin
          state_nxt = mdr_pkg::MDR_D_PARAM;
        end else if (take_query) begin
          state_nxt = mdr_pkg::MDR_D_QUERY;
        end
      end
      mdr_pkg::MDR_D_PARAM: begin
        if (last_param) begin
          // A zero count returns straight to command parsing.
          if (word_count == 20'h00000) begin
            state_nxt = mdr_pkg::MDR_D_IDLE;
          end else begin
            state_nxt = mdr_pkg::MDR_D_FETCH;
          end
        end
      end
      mdr_pkg::MDR_D_FETCH: begin
        if (mem_ack) begin
          state_nxt = mdr_pkg::MDR_D_SPLIT;
        end
      end
      mdr_pkg::MDR_D_SPLIT: begin
        if (last_split) begin
          if (left_r == 20'h00001) begin
            state_nxt = mdr_pkg::MDR_D_IDLE;
          end else begin
            state_nxt = mdr_pkg::MDR_D_FETCH;
          end
        end
      end
      mdr_pkg::MDR_D_QUERY: begin
        if (last_query) begin
          state_nxt = mdr_pkg::MDR_D_IDLE;
        end
      end
      default: begin
        state_nxt = mdr_pkg::MDR_D_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r   <= mdr_pkg::MDR_D_IDLE;
      ready_r   <= 1'b0;
      mem_req_r <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      ready_r   <= ready_nxt;
      mem_req_r <= (state_nxt == mdr_pkg::MDR_D_FETCH) & ~mem_ack;
      busy_r    <= (state_nxt != mdr_pkg::MDR_D_IDLE);
    end
  end

  // Parameter shifter; the counter restarts on every dump command.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      param_r <= 56'h0;
      pcnt_r  <= 3'h0;
    end else if (take_dump) begin
      pcnt_r  <= 3'h0;
    end else if (take_param) begin
      param_r <= param_full;
      pcnt_r  <= pcnt_r + 3'h1;
    end
  end

  // Address and words left; the address wraps inside twenty bits.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_r <= 20'h00000;
      left_r <= 20'h00000;
    end else if (last_param) begin
      addr_r <= start_addr;
      left_r <= word_count;
    end else if (last_split) begin
      addr_r <= addr_r + 20'h00001;
      left_r <= left_r - 20'h00001;
    end
  end

  // Fetched word is held while its four bytes enter the buffer.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      word_r <= 32'h0;
      bidx_r <= 2'h0;
    end else if (in_fetch & mem_ack) begin
      word_r <= mem_rdata;
      bidx_r <= 2'h0;
    end else if (push & in_split) begin
      bidx_r <= bidx_r + 2'h1;
    end
  end

  // Query reply byte index.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      qidx_r <= 1'b0;
    end else if (take_query) begin
      qidx_r <= 1'b0;
    end else if (push & in_query) begin
      qidx_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Two-entry reply buffer
  // Splitting stalls on a full buffer, so a slow host loses no byte.
  for (genvar i = 0; i < mdr_pkg::MDR_FIFO_ENTRY; i++) begin : g_ent
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        fifo_mem_r[i] <= mdr_pkg::MDR_BYTE_RST;
      end else if (push && (wr_ptr_r == 1'(i))) begin
        fifo_mem_r[i] <= push_byte;
      end
    end
  end

  // Buffer pointers and fill count.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      fcnt_r   <= 2'h0;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_r ^ pop;
      fcnt_r   <= fcnt_nxt;
    end
  end

  // ==========================================================================
  // Reply register
  // Each read loads exactly one byte; it stands until the host takes it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rep_valid_r <= 1'b0;
      rep_byte_r  <= mdr_pkg::MDR_BYTE_RST;
    end else if (take_read) begin
      rep_valid_r <= 1'b1;
      rep_byte_r  <= reply_src;
    end else if (rep_free) begin
      rep_valid_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Outputs
  assign link.cmd_ready = ready_r;
  assign link.rep_valid = rep_valid_r;
  assign link.rep_byte  = rep_byte_r;
  assign mem_req        = mem_req_r;
  assign mem_addr       = addr_r;
  assign dump_busy      = busy_r;

endmodule // mdr_dump_device

// file: src/mdr_dump_host.sv
// Host end: sends dump or query commands and drains replies with reads.
`timescale 1ns/1ps
module mdr_dump_host (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Link to the device.
  mdr_link_if.hst          link,
  // User requests.
  input  wire logic        dump_start,
  input  wire logic [23:0] dump_addr,
  input  wire logic [19:0] dump_count,
  input  wire logic        query_start,
  input  wire logic [7:0]  query_op,
  input  wire logic [7:0]  query_reads,
  // User results.
  output logic             busy,
  output logic             data_valid,
  output logic [7:0]       data_byte,
  output logic             done
);

  // ==========================================================================
  // State and storage
  mdr_pkg::mdr_host_state_e state_r;
  mdr_pkg::mdr_host_state_e state_nxt;
  logic [63:0] seq_r;
  logic [63:0] seq_nxt;
  logic [3:0]  nsend_r;
  logic [21:0] reads_r;
  logic        cmd_valid_r;
  logic [7:0]  cmd_byte_r;
  logic        rep_ready_r;
  logic        busy_r;
  logic        dvalid_r;
  logic [7:0]  dbyte_r;
  logic        done_r;

  // ==========================================================================
  // Decode
  wire        in_idle   = (state_r == mdr_pkg::MDR_H_IDLE);
  wire        in_send   = (state_r == mdr_pkg::MDR_H_SEND);
  wire        cmd_take  = cmd_valid_r & link.cmd_ready;
  wire        rep_take  = link.rep_valid & rep_ready_r;
  wire        go_dump   = in_idle & dump_start;
  wire        go_query  = in_idle & query_start & ~dump_start;
  // Count field is sent with its upper twelve bits zero.
  wire [63:0] dump_seq  = {mdr_pkg::MDR_OP_DUMP, dump_addr,
                           12'h000, dump_count};
  wire [21:0] dump_rd   = {dump_count, 2'h0};
  // At least one read follows a query, even if zero were asked.
  wire [7:0]  q_rd      = (query_reads == 8'h00) ? 8'h01 : query_reads;
  wire        last_send = cmd_take & in_send & (nsend_r == 4'h1);
  wire        last_read = rep_take & (reads_r == 22'h000001);

  // ==========================================================================
  // Next state and byte sequence
  always_comb begin
    state_nxt = state_r;
    seq_nxt   = seq_r;
    unique case (state_r)
      mdr_pkg::MDR_H_IDLE: begin
        if (go_dump) begin
          seq_nxt   = dump_seq;
          state_nxt = mdr_pkg::MDR_H_SEND;
        end else if (go_query) begin
          seq_nxt   = {query_op, 56'h0};
          // A read given as the query is itself the first read; sending it
          // and then another read would wait on a reply nobody drains.
          if (query_op == mdr_pkg::MDR_OP_READ) begin
            state_nxt = mdr_pkg::MDR_H_RDCMD;
          end else begin
            state_nxt = mdr_pkg::MDR_H_SEND;
          end
        end
      end
      mdr_pkg::MDR_H_SEND: begin
        if (cmd_take) begin
          seq_nxt = {seq_r[55:0], 8'h00};
        end
        if (last_send) begin
          // A zero word dump expects no reply bytes at all.
          if (reads_r == 22'h000000) begin
            state_nxt = mdr_pkg::MDR_H_IDLE;
          end else begin
            state_nxt = mdr_pkg::MDR_H_RDCMD;
          end
        end
      end
      mdr_pkg::MDR_H_RDCMD: begin
        if (cmd_take) begin
          state_nxt = mdr_pkg::MDR_H_RDWAIT;
        end
      end
      mdr_pkg::MDR_H_RDWAIT: begin
        if (last_read) begin
          state_nxt = mdr_pkg::MDR_H_IDLE;
        end else if (rep_take) begin
          state_nxt = mdr_pkg::MDR_H_RDCMD;
        end
      end
      default: begin
        state_nxt = mdr_pkg::MDR_H_IDLE;
      end
    endcase
  end

  wire        send_nxt  = (state_nxt == mdr_pkg::MDR_H_SEND);
  wire        rdcmd_nxt = (state_nxt == mdr_pkg::MDR_H_RDCMD);
  wire [7:0]  byte_nxt  = rdcmd_nxt ? mdr_pkg::MDR_OP_READ : seq_nxt[63:56];

  // ==========================================================================
  // Link registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r     <= mdr_pkg::MDR_H_IDLE;
      seq_r       <= 64'h0;
      cmd_valid_r <= 1'b0;
      cmd_byte_r  <= mdr_pkg::MDR_BYTE_RST;
      rep_ready_r <= 1'b0;
      busy_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      seq_r       <= seq_nxt;
      cmd_valid_r <= send_nxt | rdcmd_nxt;
      cmd_byte_r  <= byte_nxt;
      rep_ready_r <= (state_nxt == mdr_pkg::MDR_H_RDWAIT);
      busy_r      <= (state_nxt != mdr_pkg::MDR_H_IDLE);
    end
  end

  // Bytes still to send and reads still owed.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nsend_r <= 4'h0;
      reads_r <= 22'h000000;
    end else if (go_dump) begin
      nsend_r <= mdr_pkg::MDR_DUMP_BYTES;
      reads_r <= dump_rd;
    end else if (go_query) begin
      nsend_r <= mdr_pkg::MDR_QUERY_BYTES;
      reads_r <= {14'h0000, q_rd};
    end else begin
      if (cmd_take & in_send) begin
        nsend_r <= nsend_r - 4'h1;
      end
      if (rep_take) begin
        reads_r <= reads_r - 22'h000001;
      end
    end
  end

  // ==========================================================================
  // User results
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dvalid_r <= 1'b0;
      dbyte_r  <= mdr_pkg::MDR_BYTE_RST;
      done_r   <= 1'b0;
    end else begin
      dvalid_r <= rep_take;
      done_r   <= last_read | (last_send & (reads_r == 22'h000000));
      if (rep_take) begin
        dbyte_r <= link.rep_byte;
      end
    end
  end

  assign link.cmd_valid = cmd_valid_r;
  assign link.cmd_byte  = cmd_byte_r;
  assign link.rep_ready = rep_ready_r;
  assign busy           = busy_r;
  assign data_valid     = dvalid_r;
  assign data_byte      = dbyte_r;
  assign done           = done_r;

endmodule // mdr_dump_host

// file: bench/mdr_link_asserts.sv
// Protocol checker watching the command and reply link between both ends.
`timescale 1ns/1ps
// ==========================================
// Link checker
module mdr_link_asserts (
  // Clock and reset.
  input wire logic       clock,
  input wire logic       rst,
  // Command channel.
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [7:0] cmd_byte,
  // Reply channel.
  input wire logic       rep_valid,
  input wire logic       rep_ready,
  input wire logic [7:0] rep_byte
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  logic [2:0]  par_r;
  logic [31:0] cnt_r;
  logic [21:0] owe_r;

  // Parameter bytes of a dump are never commands, whatever their value.
  wire take    = cmd_valid & cmd_ready;
  wire is_par  = par_r != 3'h0;
  wire is_rd   = cmd_byte == mdr_pkg::MDR_OP_READ;
  wire is_dump = cmd_byte == mdr_pkg::MDR_OP_DUMP;
  wire rd_take = take & ~is_par & is_rd;
  wire q_take  = take & ~is_par & ~is_rd & ~is_dump;

  // Count parameters and the reads still owed for the dumped words.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      par_r <= 3'h0;
      cnt_r <= 32'h0;
      owe_r <= 22'h0;
    end else if (take && is_par) begin
      par_r <= par_r - 3'h1;
      cnt_r <= {cnt_r[23:0], cmd_byte};
      if (par_r == 3'h1) owe_r <= {cnt_r[11:0], cmd_byte, 2'h0};
    end else if (take && is_dump) begin
      par_r <= 3'h7;
    end else if (rd_take && owe_r != 22'h0) begin
      owe_r <= owe_r - 22'h1;
    end
  end

  chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_byte))
    else $error("command byte changed before it was taken");
  chk_ready_drop: assert property (take |=> !cmd_ready)
    else $error("command ready stayed high after a take");
  chk_dump_reads: assert property (take && !is_par && !is_rd |->
    owe_r == 22'h0)
    else $error("new command before all dump bytes were read");
  chk_read_reply: assert property (rd_take |=> rep_valid)
    else $error("read not answered on the next edge");
  chk_rise_needs_read: assert property ($rose(rep_valid) |->
    $past(rd_take))
    else $error("reply appeared without a read");
  chk_reply_clear: assert property (rep_valid && rep_ready |=>
    !rep_valid)
    else $error("reply stayed valid after it was taken");
  chk_reply_hold: assert property (rep_valid && !rep_ready |=>
    rep_valid && $stable(rep_byte))
    else $error("reply byte changed before it was taken");
  chk_query_read: assert property (q_take |-> ##[1:40] rd_take)
    else $error("no read issued after a query");
  chk_reset_quiet: assert property ($past(rst) |->
    !cmd_ready && !rep_valid)
    else $error("link outputs active on the first edge after reset");
endmodule // mdr_link_asserts

// file: bench/memory_dump_reply_readout_bench.sv
// Self-checking bench for the dump host and device joined by the link.
`timescale 1ns/1ps
// ==========================================
// Bench top
module memory_dump_reply_readout_bench;
  // User side, memory port and status.
  logic        clock;
  logic        rst;
  logic        dump_start;
  logic [23:0] dump_addr;
  logic [19:0] dump_count;
  logic        query_start;
  logic [7:0]  query_op;
  logic [7:0]  query_reads;
  logic        busy;
  logic        data_valid;
  logic [7:0]  data_byte;
  logic        done;
  logic        mem_req;
  logic [19:0] mem_addr;
  logic        mem_ack;
  logic [31:0] mem_rdata;
  logic [7:0]  interpreter_status_word;
  logic        dump_busy;
  int          mwait;
  int          n_mismatch;
  int          compares;
  logic [7:0]  got_q[$];
  logic [7:0]  wire_q[$];

  mdr_link_if link ();

  mdr_dump_device u_mdr_dump_device (.clock, .rst, .link (link), .mem_req,
    .mem_addr, .mem_ack, .mem_rdata, .interpreter_status_word, .dump_busy);
  mdr_dump_host u_mdr_dump_host (.clock, .rst, .link (link), .dump_start,
    .dump_addr, .dump_count, .query_start, .query_op, .query_reads,
    .busy, .data_valid, .data_byte, .done);
  mdr_link_asserts u_mdr_link_asserts (.clock, .rst,
    .cmd_valid (link.cmd_valid), .cmd_ready (link.cmd_ready),
    .cmd_byte (link.cmd_byte), .rep_valid (link.rep_valid),
    .rep_ready (link.rep_ready), .rep_byte (link.rep_byte));

  // ==========================================
  // Clock, memory and monitors
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Every word differs from its neighbours, so a wrong address shows.
  function automatic logic [31:0] mem_word(input logic [19:0] a);
    return {a[11:0] ^ 12'h5A3, a};
  endfunction

  // Memory answers after two cycles; data toggles outside the ack.
  always @(negedge clock) begin
    if (mem_req === 1'b1 && !mem_ack && mwait == 2) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem_word(mem_addr);
      mwait     <= 0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      mwait     <= (mem_req === 1'b1 && !mem_ack) ? mwait + 1 : 0;
    end
  end

  // Sampled mid-cycle, where every registered output has settled.
  always @(negedge clock) begin
    if (data_valid === 1'b1) got_q.push_back(data_byte);
    if (link.cmd_valid === 1'b1 && link.cmd_ready === 1'b1)
      wire_q.push_back(link.cmd_byte);
  end

  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Start one host request and wait, bounded, for its completion pulse.
  task automatic run(input logic d, input logic [23:0] a,
                     input logic [19:0] n, input logic [7:0] op,
                     input logic [7:0] r);
    int i;
    got_q.delete();
    wire_q.delete();
    dump_start  = d;
    query_start = !d;
    dump_addr   = a;
    dump_count  = n;
    query_op    = op;
    query_reads = r;
    @(negedge clock);
    dump_start  = 1'b0;
    query_start = 1'b0;
    for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clock);
    check(done, 32'h1, "completion");
    check(busy, 32'h0, "host idle");
    @(negedge clock);
  endtask

  // ==========================================
  // Scenarios
  task automatic dump_test(input logic [23:0] a, input logic [19:0] n);
    logic [7:0]  hdr[8];
    logic [31:0] w;
    int          i;
    hdr = '{mdr_pkg::MDR_OP_DUMP, a[23:16], a[15:8], a[7:0], 8'h00,
            {4'h0, n[19:16]}, n[15:8], n[7:0]};
    run(1'b1, a, n, 8'h00, 8'h00);
    check(32'(wire_q.size()), 32'(8 + 4 * n), "link bytes");
    check(32'(got_q.size()), 32'(4 * n), "reply bytes");
    for (i = 0; i < 8; i++)
      check(wire_q[i], hdr[i], "dump header");
    for (i = 8; i < wire_q.size(); i++)
      check(wire_q[i], mdr_pkg::MDR_OP_READ, "read byte");
    for (i = 0; i < got_q.size(); i++) begin
      w = mem_word(a[19:0] + 20'(i / 4));
      check(got_q[i], w[8 * (3 - i % 4) +: 8], "dump data");
    end
    check(dump_busy, 32'h0, "device idle");
    $display("test dump %h x %0d finished", a, n);
  endtask

  // An unknown command is a query with no status words to follow.
  task automatic query_test();
    interpreter_status_word = 8'h3C;
    run(1'b0, 24'h0, 20'h0, 8'h55, 8'h02);
    check(32'(wire_q.size()), 32'h3, "query link bytes");
    check(wire_q[0], 32'h55, "query byte");
    check(wire_q[2], mdr_pkg::MDR_OP_READ, "query read");
    check(got_q[0], mdr_pkg::MDR_QUERY_COUNT, "status count");
    check(got_q[1], 32'h3C, "interpreter status");
    $display("test query finished");
  endtask

  // A lone read in idle returns the live status byte.
  task automatic idle_read_test();
    interpreter_status_word = 8'hC3;
    run(1'b0, 24'h0, 20'h0, mdr_pkg::MDR_OP_READ, 8'h00);
    check(32'(wire_q.size()), 32'h1, "single read");
    check(32'(got_q.size()), 32'h1, "single reply");
    check(got_q[0], 32'hC3, "idle reply");
    $display("test idle read finished");
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    n_mismatch  = 0;
    compares    = 0;
    mwait       = 0;
    mem_ack     = 1'b0;
    mem_rdata   = 32'h0;
    interpreter_status_word     = 8'h00;
    dump_start  = 1'b0;
    query_start = 1'b0;
    dump_addr   = 24'h0;
    dump_count  = 20'h0;
    query_op    = 8'h00;
    query_reads = 8'h00;
    rst         = 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    dump_test(24'hF00010, 20'h00002);
    query_test();
    dump_test(24'hAFFFFF, 20'h00003);
    dump_test(24'h123456, 20'h00000);
    idle_read_test();
    end_sim();
  end

  // The tests need a few hundred cycles; twenty thousand means a hang.
  initial begin
    #2000000;
    n_mismatch++;
    end_sim();
  end
endmodule // memory_dump_reply_readout_bench
